/* src/file_op_map.svh */
// constants for the file-operation and branch execution core
`ifndef FILE_OP_MAP_SVH
`define FILE_OP_MAP_SVH
`define OPC_COMPLEMENT      4'h9
`define OPC_DECREMENT       4'h3
`define OPC_INCREMENT       4'hA
`define OPC_DEC_SKIP        4'hB
`define OPC_INC_SKIP        4'hF
`define OPC_SWAP            4'hE
`define OPC_MOVE_TO_FILE    4'h0
`define OPC_CLEAR_FILE      4'h1
`define JUMP_PREFIX         3'h5
`define STATUS_ADDR         7'h03
`define PAGE_LATCH_ADDR     7'h0A
`define COMMON_BASE         7'h70
`define STATUS_Z_BIT        2
`define STATUS_RESET        8'h18
`define PAGE_LATCH_RESET    8'h00
`define RESET_VECTOR        13'h0000
`define IRQ_VECTOR          13'h0004
`define STACK_DEPTH         8
`define BANK_WORDS          112
`define COMMON_WORDS        16
`endif

/* src/file_op_pkg.sv */
// types shared by the execution core and its data memory
package file_op_pkg;
    typedef logic [13:0] instr_t;
    typedef logic [12:0] pc_t;
    typedef logic [7:0]  byte_t;
    typedef enum logic [1:0] {
        EXEC,
        FLUSH
    } exec_state_e;
endpackage

/* src/file_data_mem.sv */
// banked data memory with a common area shared by all banks
`timescale 1ns/1ps
`default_nettype none
`include "file_op_map.svh"
module file_data_mem (
    input  wire logic              clk_i,
    input  wire logic [1:0]        bank_i,
    input  wire logic [6:0]        addr_i,
    input  wire logic              wr_en_i,
    input  wire file_op_pkg::byte_t wr_data_i,
    output file_op_pkg::byte_t     rd_data_o
);
    import file_op_pkg::*;

    // uninitialised storage, as software owns its contents
    byte_t bank_mem   [0:4*`BANK_WORDS-1];
    byte_t common_mem [0:`COMMON_WORDS-1];

    logic       is_common;
    logic [3:0] common_idx;
    logic [8:0] bank_idx;

    always_comb begin
        is_common  = (addr_i >= `COMMON_BASE);
        common_idx = addr_i[3:0];
        bank_idx   = 9'(bank_i * `BANK_WORDS) + {2'h0, addr_i};
    end

    // asynchronous read keeps single-cycle file operations
    assign rd_data_o = is_common ? common_mem[common_idx]
                                 : bank_mem[bank_idx];

    // writes land in the shared bytes when in the common area
    always_ff @(posedge clk_i) begin
        if (wr_en_i && is_common) begin
            common_mem[common_idx] <= wr_data_i;
        end
        else if (wr_en_i) begin
            bank_mem[bank_idx] <= wr_data_i;
        end
    end
endmodule
`default_nettype wire

/* src/file_op_core.sv */
// execution core for file-register operations, skips and absolute jumps
`timescale 1ns/1ps
`default_nettype none
`include "file_op_map.svh"
module file_op_core (
    input  wire logic                CORE_CLK_I,
    input  wire logic                RESETN_I,
    input  wire file_op_pkg::instr_t INSTR_I,
    input  wire logic                IRQ_I,
    output file_op_pkg::pc_t         PC_O,
    output file_op_pkg::byte_t       ACC_O,
    output file_op_pkg::byte_t       STATUS_O,
    output file_op_pkg::byte_t       PAGE_LATCH_O,
    output logic                     IRQ_ACK_O
);
    import file_op_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    exec_state_e state_ff, nxt_state;
    pc_t         pc_ff, nxt_pc;
    byte_t       acc_ff, nxt_acc;
    byte_t       status_ff, nxt_status;
    byte_t       page_latch_ff, nxt_page_latch;
    logic        ack_ff, nxt_ack;
    pc_t         stack_mem [0:`STACK_DEPTH-1];
    logic [2:0]  sp_ff, nxt_sp;
    logic        push;
    // set by a jump so that the flush cycle keeps the target address
    logic        hold_ff, nxt_hold;

    logic  [3:0] opc;
    logic        dest;
    logic  [6:0] faddr;
    byte_t       fval;
    byte_t       mem_rd;
    byte_t       result;
    logic        write_file;
    logic        is_jump;

    // zero test shared by every flag-updating operation
    function automatic logic is_zero(input byte_t v);
        return (v == 8'h00);
    endfunction

    function automatic byte_t swap_nib(input byte_t v);
        return {v[3:0], v[7:4]};
    endfunction

    // program counter step; wraps at the top of the address space
    function automatic pc_t pc_step(input pc_t v);
        return pc_t'(v + 13'h0001);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // decode
    assign opc     = INSTR_I[11:8];
    assign dest    = INSTR_I[7];
    assign faddr   = INSTR_I[6:0];
    assign is_jump = (INSTR_I[13:11] == `JUMP_PREFIX);

    // special registers are read from flops, the rest from memory
    always_comb begin
        if (faddr == `STATUS_ADDR) begin
            fval = status_ff;
        end
        else if (faddr == `PAGE_LATCH_ADDR) begin
            fval = page_latch_ff;
        end
        else begin
            fval = mem_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data memory; the direct bank select pair picks the bank
    file_data_mem u_mem (
        .clk_i     (CORE_CLK_I),
        .bank_i    (status_ff[6:5]),
        .addr_i    (faddr),
        .wr_en_i   (RESETN_I && write_file && faddr != `STATUS_ADDR
                    && faddr != `PAGE_LATCH_ADDR),
        .wr_data_i (result),
        .rd_data_o (mem_rd)
    );

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        nxt_state      = state_ff;
        nxt_pc         = pc_ff;
        nxt_acc        = acc_ff;
        nxt_status     = status_ff;
        nxt_page_latch = page_latch_ff;
        nxt_ack        = 1'b0;
        nxt_sp         = sp_ff;
        nxt_hold       = 1'b0;
        push           = 1'b0;
        result         = fval;
        write_file     = 1'b0;
        case (state_ff)
            FLUSH: begin
                // prefetched word is dropped as a no-operation; after a
                // skip the counter moves past it, after a jump it stays
                // on the target so that the target word still executes
                nxt_state = EXEC;
                if (hold_ff) begin
                    nxt_pc = pc_ff;
                end
                else begin
                    nxt_pc = pc_step(pc_ff);
                end
            end
            EXEC: begin
                nxt_pc = pc_step(pc_ff);
                if (IRQ_I) begin
                    push    = 1'b1;
                    nxt_sp  = 3'(sp_ff + 3'h1);
                    nxt_pc  = `IRQ_VECTOR;
                    nxt_ack = 1'b1;
                    // the current word is re-fetched after return
                end
                else if (is_jump) begin
                    nxt_pc    = {page_latch_ff[4:3], INSTR_I[10:0]};
                    nxt_state = FLUSH;
                    nxt_hold  = 1'b1;
                end
                else if (INSTR_I[13:12] == 2'h0) begin
                    case (opc)
                        `OPC_COMPLEMENT: result = ~fval;
                        `OPC_DECREMENT:  result = byte_t'(fval - 8'h01);
                        `OPC_INCREMENT:  result = byte_t'(fval + 8'h01);
                        `OPC_DEC_SKIP:   result = byte_t'(fval - 8'h01);
                        `OPC_INC_SKIP:   result = byte_t'(fval + 8'h01);
                        `OPC_SWAP:       result = swap_nib(fval);
                        `OPC_MOVE_TO_FILE: result = acc_ff;
                        `OPC_CLEAR_FILE: result = 8'h00;
                        default:         result = fval;
                    endcase
                    if (opc == `OPC_MOVE_TO_FILE || opc == `OPC_CLEAR_FILE)
                    begin
                        write_file = dest;
                    end
                    else if (dest) begin
                        write_file = 1'b1;
                    end
                    else begin
                        nxt_acc = result;
                    end
                    // status written as a file register
                    if (write_file && faddr == `STATUS_ADDR) begin
                        nxt_status = result;
                    end
                    if (write_file && faddr == `PAGE_LATCH_ADDR) begin
                        nxt_page_latch = result;
                    end
                    if (opc == `OPC_COMPLEMENT || opc == `OPC_DECREMENT
                        || opc == `OPC_INCREMENT
                        || opc == `OPC_CLEAR_FILE) begin
                        nxt_status[`STATUS_Z_BIT] = is_zero(result);
                    end
                    if ((opc == `OPC_DEC_SKIP || opc == `OPC_INC_SKIP)
                        && is_zero(result)) begin
                        nxt_state = FLUSH;
                    end
                end
            end
            default: nxt_state = EXEC;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registers; synchronous reset
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            state_ff      <= EXEC;
            pc_ff         <= `RESET_VECTOR;
            acc_ff        <= 8'h00;
            status_ff     <= `STATUS_RESET;
            page_latch_ff <= `PAGE_LATCH_RESET;
            ack_ff        <= 1'b0;
            sp_ff         <= 3'h0;
            hold_ff       <= 1'b0;
        end
        else begin
            state_ff      <= nxt_state;
            pc_ff         <= nxt_pc;
            acc_ff        <= nxt_acc;
            status_ff     <= nxt_status;
            page_latch_ff <= nxt_page_latch;
            ack_ff        <= nxt_ack;
            sp_ff         <= nxt_sp;
            hold_ff       <= nxt_hold;
        end
    end

    // stack storage; holds the interrupted address only, and nothing
    // lands while reset is held
    always_ff @(posedge CORE_CLK_I) begin
        if (push && RESETN_I) begin
            stack_mem[sp_ff] <= pc_ff;
        end
    end

    assign PC_O         = pc_ff;
    assign ACC_O        = acc_ff;
    assign STATUS_O     = status_ff;
    assign PAGE_LATCH_O = page_latch_ff;
    assign IRQ_ACK_O    = ack_ff;
endmodule
`default_nettype wire

/* testbench/prog_rom.sv */
// program memory model feeding instruction words to the core
`timescale 1ns/1ps
`default_nettype none
module prog_rom (
    input  wire file_op_pkg::pc_t addr_i,
    output file_op_pkg::instr_t   instr_o
);
    import file_op_pkg::*;
    instr_t rom [256];
    ////////////////////////////////////////////////////////////
    // combinational fetch; only the low byte decodes, upper pages alias
    assign instr_o = rom[addr_i[7:0]];
endmodule
`default_nettype wire

/* testbench/file_op_core_sva.sv */
// concurrent checks on the execution core's ports
`timescale 1ns/1ps
`default_nettype none
`include "file_op_map.svh"
module file_op_core_sva (
    input wire logic                CORE_CLK_I,
    input wire logic                RESETN_I,
    input wire file_op_pkg::instr_t INSTR_I,
    input wire logic                IRQ_I,
    input wire file_op_pkg::pc_t    PC_O,
    input wire file_op_pkg::byte_t  ACC_O,
    input wire file_op_pkg::byte_t  STATUS_O,
    input wire file_op_pkg::byte_t  PAGE_LATCH_O,
    input wire logic                IRQ_ACK_O
);
    import file_op_pkg::*;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    logic        ex_ff;
    logic        nxt_ex;
    logic        go;
    logic        fo;
    logic [11:0] op;
    ////////////////////////////////////////////////////////////
    // only a cycle after reset or a plain op is surely executing; skips are opaque
    always_comb begin
        go     = ex_ff && !IRQ_I;
        fo     = go && INSTR_I[13:12] == 2'b00;
        op     = INSTR_I[11:0];
        nxt_ex = !IRQ_I && INSTR_I[13:12] == 2'b00
                 && op[11:8] != `OPC_DEC_SKIP && op[11:8] != `OPC_INC_SKIP;
    end
    always_ff @(posedge CORE_CLK_I) begin
        ex_ff <= !RESETN_I || nxt_ex;
    end
    a_jump_target: assert property (go && INSTR_I[13:11] == `JUMP_PREFIX
        |=> PC_O == {$past(PAGE_LATCH_O[4:3]), $past(INSTR_I[10:0])}
        && $stable(STATUS_O) ##1 PC_O == $past(PC_O))
        else $error("jump target or flush wrong");
    a_irq_entry: assert property (ex_ff && IRQ_I |=> PC_O == `IRQ_VECTOR
        && IRQ_ACK_O && $stable(ACC_O) && $stable(STATUS_O))
        else $error("interrupt entry wrong");
    a_step_one: assert property (fo && nxt_ex |=>
        PC_O == $past(PC_O) + 13'h1) else $error("plain op not one cycle");
    a_comp_zero: assert property (fo
        && op == {`OPC_COMPLEMENT, 1'b0, `STATUS_ADDR}
        |=> ACC_O == ~$past(STATUS_O)
        && STATUS_O[`STATUS_Z_BIT] == (ACC_O == 8'h00))
        else $error("complement or zero flag wrong");
    a_swap_keep: assert property (fo
        && op == {`OPC_SWAP, 1'b0, `STATUS_ADDR}
        |=> ACC_O == {$past(STATUS_O[3:0]), $past(STATUS_O[7:4])}
        && $stable(STATUS_O)) else $error("swap wrong");
    a_inc_flags: assert property (fo
        && op == {`OPC_INCREMENT, 1'b0, `STATUS_ADDR}
        |=> ACC_O == $past(STATUS_O) + 8'h01
        && ((STATUS_O ^ $past(STATUS_O)) & 8'hFB) == 8'h00)
        else $error("increment result or flags wrong");
    a_skip_flags: assert property (fo && (op[11:8] == `OPC_DEC_SKIP
        || op[11:8] == `OPC_INC_SKIP)
        && !(op[7] && op[6:0] == `STATUS_ADDR) |=> $stable(STATUS_O))
        else $error("skip changed status");
    a_clear_bank: assert property (fo
        && op == {`OPC_CLEAR_FILE, 1'b1, `STATUS_ADDR}
        |=> STATUS_O[7:5] == 3'b000 && STATUS_O[`STATUS_Z_BIT])
        else $error("status clear left bank bits");
endmodule
`default_nettype wire

/* testbench/tb_file_op_core.sv */
// self-checking bench for the file-operation and branch execution core
`timescale 1ns/1ps
`default_nettype none
`include "file_op_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_file_op_core;
    import file_op_pkg::*;
    logic   clk         = 1'b0;
    logic   rst_n       = 1'b0;
    logic   irq         = 1'b0;
    instr_t instr;
    pc_t    pc;
    byte_t  acc;
    byte_t  status;
    byte_t  latch;
    logic   ack;
    int     fails       = 0;
    int     checks_done = 0;
    ////////////////////////////////////////////////////////////
    // 40 MHz core clock
    always #12.5 clk = ~clk;
    file_op_core i_file_op_core (.CORE_CLK_I(clk), .RESETN_I(rst_n),
        .INSTR_I(instr), .IRQ_I(irq), .PC_O(pc), .ACC_O(acc),
        .STATUS_O(status), .PAGE_LATCH_O(latch), .IRQ_ACK_O(ack));
    prog_rom i_prog_rom (.addr_i(pc), .instr_o(instr));
    function automatic instr_t fop(input logic [3:0] o, input logic d,
                                   input logic [6:0] f);
        return {2'b00, o, d, f};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // reload under reset; spare words park acc in 22h, harmless filler
    task automatic restart(input int n, input instr_t p[$]);
        rst_n = 1'b0;
        for (int a = 0; a < 256; a++)
            i_prog_rom.rom[a] = fop(`OPC_MOVE_TO_FILE, 1'b1, 7'h22);
        foreach (p[a]) i_prog_rom.rom[a] = p[a];
        step(n);
        rst_n = 1'b1;
    endtask
    task automatic sc_jump();
        restart(20, '{fop(`OPC_INCREMENT, 1'b0, `STATUS_ADDR),
            fop(`OPC_MOVE_TO_FILE, 1'b1, `PAGE_LATCH_ADDR),
            {`JUMP_PREFIX, 11'h7FF}});
        // the jump target aliases onto the last word of the model
        i_prog_rom.rom[255] = fop(`OPC_COMPLEMENT, 1'b0, `STATUS_ADDR);
        step(1);
        `CHK(acc, 8'h19)
        `CHK(status, `STATUS_RESET)
        step(1);
        `CHK(latch, 8'h19)
        step(1);
        `CHK(pc, 13'h1FFF)
        step(1);
        `CHK(pc, 13'h1FFF)
        step(1);
        `CHK(pc, 13'h0000)
        `CHK(acc, 8'hE7)
    endtask
    task automatic sc_skip();
        restart(2, '{fop(`OPC_CLEAR_FILE, 1'b1, 7'h21),
            fop(`OPC_INCREMENT, 1'b1, 7'h21), fop(`OPC_DEC_SKIP, 1'b1, 7'h21),
            fop(`OPC_COMPLEMENT, 1'b0, `STATUS_ADDR),
            fop(`OPC_INC_SKIP, 1'b1, 7'h21), fop(`OPC_COMPLEMENT, 1'b0, 7'h21)});
        step(2);
        `CHK(acc, 8'h00)
        `CHK(status, `STATUS_RESET)
        step(2);
        `CHK(pc, 13'h0004)
        `CHK(acc, 8'h00)
        step(2);
        `CHK(acc, 8'hFE)
        `CHK(pc, 13'h0006)
    endtask
    // common byte written in bank 0 must read back from bank 1
    task automatic sc_bank();
        restart(2, '{fop(`OPC_CLEAR_FILE, 1'b1, 7'h70),
            fop(`OPC_DECREMENT, 1'b1, 7'h70), fop(`OPC_CLEAR_FILE, 1'b1, 7'h21),
            fop(`OPC_INCREMENT, 1'b1, 7'h21), fop(`OPC_INCREMENT, 1'b1, 7'h21),
            fop(`OPC_SWAP, 1'b0, 7'h21),
            fop(`OPC_MOVE_TO_FILE, 1'b1, `STATUS_ADDR),
            fop(`OPC_COMPLEMENT, 1'b0, 7'h70),
            fop(`OPC_CLEAR_FILE, 1'b1, `STATUS_ADDR),
            fop(`OPC_COMPLEMENT, 1'b0, 7'h21)});
        step(7);
        `CHK(acc, 8'h20)
        `CHK(status, 8'h20)
        step(1);
        `CHK(acc, 8'h00)
        `CHK(status, 8'h24)
        step(1);
        `CHK(status, 8'h04)
        step(1);
        `CHK(acc, 8'hFD)
    endtask
    task automatic sc_irq();
        restart(2, '{fop(`OPC_COMPLEMENT, 1'b0, `STATUS_ADDR),
            fop(`OPC_SWAP, 1'b0, `STATUS_ADDR)});
        step(2);
        `CHK(acc, 8'h81)
        irq = 1'b1;
        step(1);
        irq = 1'b0;
        `CHK(pc, `IRQ_VECTOR)
        `CHK(ack, 1'b1)
        `CHK(acc, 8'h81)
        `CHK(status, `STATUS_RESET)
        `CHK(i_file_op_core.stack_mem[0], 13'h0002)
        step(1);
        `CHK(ack, 1'b0)
    endtask
    task automatic close_out();
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        sc_jump();
        sc_skip();
        sc_bank();
        sc_irq();
        close_out();
    end
endmodule
bind file_op_core file_op_core_sva i_file_op_core_sva (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .INSTR_I(INSTR_I),
    .IRQ_I(IRQ_I), .PC_O(PC_O), .ACC_O(ACC_O), .STATUS_O(STATUS_O),
    .PAGE_LATCH_O(PAGE_LATCH_O), .IRQ_ACK_O(IRQ_ACK_O));
`default_nettype wire
